//--- logic/bdsc_regs.sv
/*
 Device-specific configuration registers of a bridge: chip control,
 diagnostic control with self-clearing chip reset, arbiter priority control.
 Assumes byte-wide configuration writes and reads arriving on the core clock,
 and that the arbiter, target and router logic consume the control outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bdsc_defines.svh"
module bdsc_regs
(
    input  wire logic        clock,                 // 40 MHz core clock
    input  wire logic        rst_b,                 // Primary reset, active low
    input  wire logic        clock_en,              // Freezes all state when low
    input  wire logic [7:0]  cfg_addr,              // Configuration byte offset
    input  wire logic        cfg_write,             // Write strobe
    input  wire logic        cfg_read,              // Read strobe
    input  wire logic [7:0]  cfg_wdata,             // Write data
    output logic      [7:0]  cfg_rdata,             // Read data, one cycle later
    input  wire logic        private_strap_input,   // Strap pin for private enables
    input  wire logic [15:0] private_memory_base,   // Private base, 64 KB units
    input  wire logic [15:0] private_memory_limit,  // Private limit, 64 KB units
    input  wire logic [15:0] target_addr,           // Target address bits 31:16
    input  wire logic [11:0] target_low_addr,       // Target address bits 11:0
    input  wire logic        target_queue_full,     // Posting queue full
    input  wire logic        target_mem_write,      // Target memory write phase
    input  wire logic [3:0]  read_command,          // Upstream read command code
    input  wire logic [7:0]  idsel_request,         // IDSEL onehot for S_AD[23:16]
    input  wire logic        reroute_no_devsel,     // Rerouted cycle got no answer
    input  wire logic        bridge_control_sec_wr, // Software write of sec reset
    input  wire logic        bridge_control_sec_val,// Value written
    output logic             bridge_control_sec,    // Bridge control sec reset bit
    output logic             secondary_reset_output,// Secondary reset, active high
    output logic             chip_reset_active,     // Whole-chip reset pulse, four cycles
    output logic             target_disconnect,     // Disconnect this data phase
    output logic             primary_private_block, // Primary hits private range
    output logic             secondary_private_ign, // Secondary ignores the cycle
    output logic             idsel_line24,          // Drive IDSEL on line 24
    output logic [7:0]       idsel_out,             // IDSEL on lines 23:16
    output logic             reroute_master_abort,  // End rerouted cycle aborted
    output logic             upstream_prefetch,     // Prefetch this upstream read
    output logic             forward_byte_enables,  // Forward requester byte enables
    output logic             single_dword_disc,     // Disconnect after first data
    output logic [7:0]       request_high_group,    // Per request high group
    output logic             own_port_high_group    // Own port high group
);
    logic [7:0]  chip_control;
    logic [7:0]  diagnostic_control;
    logic [15:0] arbiter_priority_control;
    logic        strap_sync;
    logic        strap_pending;
    logic [1:0]  strap_wait;
    logic [3:0]  reset_count;
    bdsc_pkg::bdsc_reset_state_t reset_state;
    logic        next_disconnect;
    logic        range_valid;
    logic        in_range;
    logic        prefetchable_cmd;

    bdsc_sync u_strap_sync
    (
        .clock  (clock),
        .rst_b  (rst_b),
        .enable (clock_en),
        .d      (private_strap_input),
        .q      (strap_sync)
    );

    wire wr_cc = cfg_write && (cfg_addr == `BDSC_OFF_CHIP_CONTROL);
    wire wr_dc = cfg_write && (cfg_addr == `BDSC_OFF_DIAGNOSTIC_CONTROL);
    wire wr_al = cfg_write && (cfg_addr == `BDSC_OFF_ARBITER_LOW);
    wire wr_ah = cfg_write && (cfg_addr == `BDSC_OFF_ARBITER_HIGH);
    wire chip_rst_req = wr_dc && cfg_wdata[`BDSC_DC_CHIPRST_BIT];
    wire soft_reset   = (reset_state == bdsc_pkg::BDSC_RST_HOLD);

    // Chip reset sequencer; writing zero is simply not a trigger
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reset_state <= bdsc_pkg::BDSC_RST_IDLE;
            reset_count <= 4'h0;
        end
        else if (clock_en)
        begin
            case (reset_state)
                bdsc_pkg::BDSC_RST_IDLE:
                begin
                    if (chip_rst_req)
                    begin
                        reset_state <= bdsc_pkg::BDSC_RST_HOLD;
                        reset_count <= `BDSC_RESET_CYCLES;
                    end
                end
                bdsc_pkg::BDSC_RST_HOLD:
                begin
                    if (reset_count == 4'h1)
                        reset_state <= bdsc_pkg::BDSC_RST_DONE;
                    reset_count <= reset_count - 4'h1;
                end
                bdsc_pkg::BDSC_RST_DONE:
                    reset_state <= bdsc_pkg::BDSC_RST_IDLE;
                default:
                    reset_state <= bdsc_pkg::BDSC_RST_IDLE;
            endcase
        end
    end

    // Synchroniser flops start at zero, so capture runs until they hold the pin
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            strap_wait <= `BDSC_STRAP_WAIT;
        else if (clock_en)
        begin
            if (soft_reset)
                strap_wait <= `BDSC_STRAP_REWAIT;
            else if (strap_wait != 2'h0)
                strap_wait <= strap_wait - 2'h1;
        end
    end
    assign strap_pending = (strap_wait != 2'h0);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            chip_control <= `BDSC_CC_RESET;
        else if (clock_en)
        begin
            if (soft_reset)
                chip_control <= `BDSC_CC_RESET;
            else if (strap_pending)
            begin
                chip_control[`BDSC_CC_PVTMEM_BIT] <= strap_sync;
                chip_control[`BDSC_CC_PVTDEV_BIT] <= strap_sync;
            end
            else if (wr_cc)
                chip_control <= {3'h0, cfg_wdata[4:1], 1'b0};
        end
    end

    // Bits 2:1 are writable scratch; bit 3 and 7:4 stay zero
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            diagnostic_control <= `BDSC_DC_RESET;
        else if (clock_en)
        begin
            if (soft_reset || (reset_state == bdsc_pkg::BDSC_RST_DONE))
                diagnostic_control <= `BDSC_DC_RESET;
            else if (chip_rst_req)
                diagnostic_control <= {4'h0, 1'b0, cfg_wdata[2:1], 1'b1};
            else if (wr_dc)
                diagnostic_control <= {4'h0, 1'b0, cfg_wdata[2:1],
                                       diagnostic_control[0]};
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            arbiter_priority_control <= `BDSC_AC_RESET;
        else if (clock_en)
        begin
            if (soft_reset)
                arbiter_priority_control <= `BDSC_AC_RESET;
            else
            begin
                if (wr_al)
                    arbiter_priority_control[7:0] <= cfg_wdata;
                if (wr_ah)
                    arbiter_priority_control[15:8] <= {cfg_wdata[7:4], 2'b00,
                                                       cfg_wdata[1:0]};
            end
        end
    end

    // Bridge control sec reset bit survives the chip reset it was set by
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            bridge_control_sec <= 1'b0;
        else if (clock_en)
        begin
            if (chip_rst_req || soft_reset)
                bridge_control_sec <= 1'b1;
            else if (bridge_control_sec_wr)
                bridge_control_sec <= bridge_control_sec_val;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secondary_reset_output <= 1'b1;
            chip_reset_active      <= 1'b0;
        end
        else if (clock_en)
        begin
            secondary_reset_output <= bridge_control_sec || soft_reset;
            chip_reset_active      <= soft_reset;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cfg_rdata <= 8'h00;
        else if (clock_en)
        begin
            if (!cfg_read)
                cfg_rdata <= 8'h00;
            else
            begin
                case (cfg_addr)
                    `BDSC_OFF_CHIP_CONTROL:       cfg_rdata <= chip_control;
                    `BDSC_OFF_DIAGNOSTIC_CONTROL: cfg_rdata <= diagnostic_control;
                    `BDSC_OFF_ARBITER_LOW:        cfg_rdata <= arbiter_priority_control[7:0];
                    `BDSC_OFF_ARBITER_HIGH:       cfg_rdata <= arbiter_priority_control[15:8];
                    default:                      cfg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Target disconnect policy
    always_comb
    begin
        next_disconnect = target_queue_full || (target_low_addr == 12'hFFC);
        if (chip_control[`BDSC_CC_WRDISC_BIT] &&
            (target_low_addr[4:0] == 5'(`BDSC_CACHE_LINE_BYTES - 8'h04)))
            next_disconnect = 1'b1;
        next_disconnect = next_disconnect && target_mem_write;
    end

    assign range_valid = !(private_memory_limit < private_memory_base);
    assign in_range    = (target_addr >= private_memory_base) &&
                         (target_addr <= private_memory_limit);
    // Memory read line (E) and read multiple (C) are always prefetchable
    assign prefetchable_cmd = (read_command == 4'hE) || (read_command == 4'hC);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            target_disconnect     <= 1'b0;
            primary_private_block <= 1'b0;
            secondary_private_ign <= 1'b0;
            idsel_line24          <= 1'b0;
            idsel_out             <= 8'h00;
            reroute_master_abort  <= 1'b0;
            upstream_prefetch     <= 1'b0;
            forward_byte_enables  <= 1'b0;
            single_dword_disc     <= 1'b0;
            request_high_group    <= 8'h00;
            own_port_high_group   <= 1'b1;
        end
        else if (clock_en)
        begin
            target_disconnect     <= next_disconnect;
            primary_private_block <= chip_control[`BDSC_CC_PVTMEM_BIT] && range_valid
                                     && in_range;
            secondary_private_ign <= chip_control[`BDSC_CC_PVTMEM_BIT] && range_valid
                                     && in_range;
            if (chip_control[`BDSC_CC_PVTDEV_BIT])
            begin
                idsel_line24 <= |idsel_request;
                idsel_out    <= 8'h00;
            end
            else
            begin
                idsel_line24 <= 1'b0;
                idsel_out    <= idsel_request;
            end
            reroute_master_abort  <= chip_control[`BDSC_CC_PVTDEV_BIT]
                                     && reroute_no_devsel;
            upstream_prefetch     <= !chip_control[`BDSC_CC_NOPREF_BIT]
                                     || prefetchable_cmd;
            forward_byte_enables  <= chip_control[`BDSC_CC_NOPREF_BIT]
                                     && !prefetchable_cmd;
            single_dword_disc     <= chip_control[`BDSC_CC_NOPREF_BIT]
                                     && !prefetchable_cmd;
            request_high_group    <= arbiter_priority_control[7:0];
            own_port_high_group   <= arbiter_priority_control[`BDSC_AC_OWN_BIT];
        end
    end

    sequence chip_rst_seq;
        clock_en && chip_rst_req && (reset_state == bdsc_pkg::BDSC_RST_IDLE);
    endsequence

    sequence sec_held_seq;
        clock_en ##1 bridge_control_sec;
    endsequence

    property chip_rst_p;
        @(posedge clock) disable iff (!rst_b)
        chip_rst_seq |=> soft_reset;
    endproperty

    chip_rst_go_a: assert property (chip_rst_p)
        else $error("chip reset write did not start reset");

    sec_reset_out_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && bridge_control_sec) |=> secondary_reset_output)
        else $error("secondary reset output not held");

    chip_rst_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reset_state == bdsc_pkg::BDSC_RST_DONE && clock_en) |=>
        (!diagnostic_control[0] && bridge_control_sec))
        else $error("chip reset bit not cleared or sec bit lost");

    mask_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        !diagnostic_control[3] && diagnostic_control[7:4] == 4'h0)
        else $error("diagnostic reserved bits not zero");

    arb_res_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        arbiter_priority_control[11:10] == 2'b00 && chip_control[7:5] == 3'h0
        && !chip_control[0])
        else $error("reserved read-only bits not zero");

    private_range_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && private_memory_limit < private_memory_base) |=>
        !primary_private_block)
        else $error("private range active with limit below base");

    reroute_idsel_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && chip_control[`BDSC_CC_PVTDEV_BIT] && |idsel_request) |=>
        (idsel_line24 && idsel_out == 8'h00))
        else $error("IDSEL not rerouted to line 24");

    prefetch_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && !chip_control[`BDSC_CC_NOPREF_BIT]) |=>
        (upstream_prefetch && !forward_byte_enables))
        else $error("prefetch mode wrong");

    line_prefetch_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && prefetchable_cmd) |=> upstream_prefetch)
        else $error("read line or multiple not prefetched");

    own_group_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && wr_ah && !soft_reset) |=> ##1
        (!$past(clock_en) || own_port_high_group == $past(cfg_wdata[1], 2)))
        else $error("own port group not following control bit");

    disc_policy_a: assert property (@(posedge clock) disable iff (!rst_b)
        (clock_en && target_mem_write && target_queue_full) |=> target_disconnect)
        else $error("no disconnect on queue full");

    held_sec_a: assert property (@(posedge clock) disable iff (!rst_b)
        sec_held_seq |=> (!$past(clock_en) || secondary_reset_output))
        else $error("reset output dropped while sec bit set");
endmodule : bdsc_regs
`default_nettype wire

//--- common/bdsc_defines.svh
/*
 Holds the offsets, field positions, reset values and timing counts of the
 bridge device-specific control registers.
 Assumes it is included by its bare name by the design files.
*/
`ifndef BDSC_DEFINES_SVH
`define BDSC_DEFINES_SVH

`define BDSC_OFF_CHIP_CONTROL        8'h40
`define BDSC_OFF_DIAGNOSTIC_CONTROL  8'h41
`define BDSC_OFF_ARBITER_LOW         8'h42
`define BDSC_OFF_ARBITER_HIGH        8'h43

`define BDSC_CC_WRDISC_BIT           1
`define BDSC_CC_PVTMEM_BIT           2
`define BDSC_CC_PVTDEV_BIT           3
`define BDSC_CC_NOPREF_BIT           4
`define BDSC_DC_CHIPRST_BIT          0
`define BDSC_AC_OWN_BIT              9

`define BDSC_CC_RESET                8'h00
`define BDSC_DC_RESET                8'h00
`define BDSC_AC_RESET                16'h0200

`define BDSC_CACHE_LINE_BYTES        8'h20
`define BDSC_RESET_CYCLES            4'h4
`define BDSC_STRAP_WAIT              2'h3
`define BDSC_STRAP_REWAIT            2'h1

`endif

//--- common/bdsc_pkg.sv
/*
 Types shared by the bridge device-specific control design.
 Assumes the defines header is compiled alongside.
*/
`default_nettype none
package bdsc_pkg;
    typedef enum logic [1:0] {
        BDSC_RST_IDLE,
        BDSC_RST_HOLD,
        BDSC_RST_DONE
    } bdsc_reset_state_t;
endpackage : bdsc_pkg
`default_nettype wire

//--- logic/bdsc_sync.sv
/*
 Two-stage synchroniser for one level coming from a pin.
 Assumes the level is quasi-static compared with the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bdsc_sync
(
    input  wire logic clock,   // Core clock
    input  wire logic rst_b,   // Asynchronous reset, active low
    input  wire logic enable,  // Clock enable
    input  wire logic d,       // Pin level
    output logic      q        // Synchronised level
);
    logic stage1;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= 1'b0;
            q      <= 1'b0;
        end
        else if (enable)
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : bdsc_sync
`default_nettype wire

//--- bench/bdsc_sec_agent.sv
/*
 Model of the secondary bus agents that a rerouted configuration cycle reaches.
 Assumes the bridge raises its line-24 select one cycle after the request.
*/
`timescale 1ns/1ps
`default_nettype none
module bdsc_sec_agent
(
    input  wire logic clock,            // Core clock
    input  wire logic rst_b,            // Reset, active low
    input  wire logic line24_present,   // A device sits on line 24
    input  wire logic idsel_line24,     // Select driven on line 24
    output logic      reroute_no_devsel // No device claimed the cycle
);
    // A missing device never claims, so the bridge must abort on its own
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            reroute_no_devsel <= 1'b0;
        else
            reroute_no_devsel <= idsel_line24 & ~line24_present;
    end
endmodule : bdsc_sec_agent
`default_nettype wire

//--- bench/testbench.sv
/*
 Self-checking bench for the bridge device-specific control registers.
 Assumes byte configuration accesses and registered outputs one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bdsc_defines.svh"
module testbench;
    logic        clock, rst_b, clock_en, cfg_write, cfg_read, strap, tq_full, tmw, nodev;
    logic        bc_wr, bc_val, present, bc_sec, sro, cra, tdisc, ppb, spi, l24, rma;
    logic        pref, fbe, sdd, own;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, idsel_req, idsel_out, rhg;
    logic [15:0] pbase, plimit, taddr;
    logic [11:0] tlow;
    logic [3:0]  rcmd;
    int          errors, n_tests, i;

    bdsc_regs u_dut (.clock(clock), .rst_b(rst_b), .clock_en(clock_en),
        .cfg_addr(cfg_addr), .cfg_write(cfg_write), .cfg_read(cfg_read),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .private_strap_input(strap),
        .private_memory_base(pbase), .private_memory_limit(plimit), .target_addr(taddr),
        .target_low_addr(tlow), .target_queue_full(tq_full), .target_mem_write(tmw),
        .read_command(rcmd), .idsel_request(idsel_req), .reroute_no_devsel(nodev),
        .bridge_control_sec_wr(bc_wr), .bridge_control_sec_val(bc_val),
        .bridge_control_sec(bc_sec), .secondary_reset_output(sro),
        .chip_reset_active(cra), .target_disconnect(tdisc), .primary_private_block(ppb),
        .secondary_private_ign(spi), .idsel_line24(l24), .idsel_out(idsel_out),
        .reroute_master_abort(rma), .upstream_prefetch(pref), .forward_byte_enables(fbe),
        .single_dword_disc(sdd), .request_high_group(rhg), .own_port_high_group(own));

    bdsc_sec_agent u_agent (.clock(clock), .rst_b(rst_b), .line24_present(present),
        .idsel_line24(l24), .reroute_no_devsel(nodev));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic step();
        @(posedge clock);
        #2;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_write = 1'b1;
        step();
        cfg_write = 1'b0;
        step();
    endtask : wr

    // Read data stands for one cycle only, so it is sampled right away
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cfg_addr = a;
        cfg_read = 1'b1;
        step();
        cfg_read = 1'b0;
        chk({8'h00, cfg_rdata}, {8'h00, exp});
        step();
    endtask : rd

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic bounded_fail();
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask : bounded_fail

    initial
    begin
        {rst_b, cfg_write, cfg_read, tq_full, tmw, bc_wr, bc_val, present} = '0;
        {clock_en, strap} = 2'b11;
        {cfg_addr, cfg_wdata, idsel_req, pbase, plimit, taddr, tlow, rcmd} = '0;
        errors = 0;
        n_tests = 0;
        repeat (2) @(posedge clock);
        #2 rst_b = 1'b1;
        // Strap reaches chip_control only once both synchroniser flops hold it
        repeat (3) step();
        rd(`BDSC_OFF_CHIP_CONTROL, 8'h0C);
        rd(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'h00);
        rd(`BDSC_OFF_ARBITER_LOW, 8'h00);
        rd(`BDSC_OFF_ARBITER_HIGH, 8'h02);
        rd(8'h44, 8'h00);
        chk(own, 1'b1);
        $display("test reset values done");
        wr(`BDSC_OFF_CHIP_CONTROL, 8'hFF);
        rd(`BDSC_OFF_CHIP_CONTROL, 8'h1E);
        wr(`BDSC_OFF_CHIP_CONTROL, 8'h00);
        rd(`BDSC_OFF_CHIP_CONTROL, 8'h00);
        wr(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'hF8);
        rd(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'h00);
        wr(`BDSC_OFF_ARBITER_LOW, 8'hA5);
        wr(`BDSC_OFF_ARBITER_HIGH, 8'h0C);
        step();
        chk(rhg, 8'hA5);
        chk(own, 1'b0);
        rd(`BDSC_OFF_ARBITER_HIGH, 8'h00);
        clock_en = 1'b0;
        wr(`BDSC_OFF_ARBITER_LOW, 8'h3C);
        clock_en = 1'b1;
        rd(`BDSC_OFF_ARBITER_LOW, 8'hA5);
        chk(rhg, 8'hA5);
        $display("test register access done");
        // Disconnect table: control bit, queue full, low address, expected
        for (i = 0; i < 10; i++)
        begin
            wr(`BDSC_OFF_CHIP_CONTROL, (i >= 5) ? 8'h02 : 8'h00);
            tmw = (i % 5) != 4;
            tq_full = (i % 5) == 0;
            tlow = ((i % 5) == 1) ? 12'hFFC : (((i % 5) == 2) ? 12'h01C : 12'h010);
            step();
            step();
            chk(tdisc, (i % 5) < 2 || i == 7);
        end
        tmw = 1'b0;
        tq_full = 1'b0;
        $display("test disconnect done");
        // Private table: enable, limit, address, expected block
        for (i = 0; i < 4; i++)
        begin
            wr(`BDSC_OFF_CHIP_CONTROL, (i == 3) ? 8'h00 : 8'h04);
            pbase = 16'h0010;
            plimit = (i == 2) ? 16'h000F : 16'h0020;
            taddr = (i == 1) ? 16'h0030 : 16'h0020;
            step();
            step();
            chk({ppb, spi}, (i == 0) ? 2'b11 : 2'b00);
        end
        $display("test private memory done");
        idsel_req = 8'h04;
        wr(`BDSC_OFF_CHIP_CONTROL, 8'h00);
        step();
        chk({l24, idsel_out}, 9'h004);
        wr(`BDSC_OFF_CHIP_CONTROL, 8'h08);
        step();
        chk({l24, idsel_out}, 9'h100);
        for (i = 0; i < 10 && rma !== 1'b1; i++)
            step();
        if (i == 10)
            bounded_fail();
        chk(rma, 1'b1);
        present = 1'b1;
        step();
        step();
        step();
        chk(rma, 1'b0);
        idsel_req = 8'h00;
        $display("test reroute done");
        rcmd = 4'h6;
        wr(`BDSC_OFF_CHIP_CONTROL, 8'h00);
        step();
        chk({pref, fbe, sdd}, 3'b100);
        wr(`BDSC_OFF_CHIP_CONTROL, 8'h10);
        step();
        chk({pref, fbe, sdd}, 3'b011);
        rcmd = 4'hE;
        step();
        step();
        chk(pref, 1'b1);
        rcmd = 4'hC;
        step();
        step();
        chk(pref, 1'b1);
        $display("test prefetch done");
        wr(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'h00);
        step();
        chk(cra, 1'b0);
        wr(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'h01);
        chk(bc_sec, 1'b1);
        for (i = 0; i < 20 && cra !== 1'b1; i++)
            step();
        if (i == 20)
            bounded_fail();
        chk(sro, 1'b1);
        for (i = 0; i < 20 && cra !== 1'b0; i++)
            step();
        if (i == 20)
            bounded_fail();
        step();
        step();
        rd(`BDSC_OFF_DIAGNOSTIC_CONTROL, 8'h00);
        rd(`BDSC_OFF_ARBITER_LOW, 8'h00);
        rd(`BDSC_OFF_CHIP_CONTROL, 8'h0C);
        chk({bc_sec, sro}, 2'b11);
        bc_wr = 1'b1;
        step();
        bc_wr = 1'b0;
        step();
        chk({bc_sec, sro}, 2'b00);
        $display("test chip reset done");
        report_and_stop();
    end

    initial
    begin
        #2000000;
        errors++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
